/* File: design/crc_consts.svh */
// Notes on behaviour
// - Polynomial order up to 32; five-bit length field plus one gives highest exponent.
// - Each set polynomial term bit enables an XOR feedback at that position.
// - Constant term always XORed; bit 0 ignored; order-32 top term implied.
// - Data width 1 to 32 bits, equal to width field plus one.
// - FIFO depth 4 above 15, 8 for 8 to 15, 16 below 8.
// - Writes are at least a byte; bits above the data width ignored.
// - Writing the width's most significant data bit completes an entry, count plus one.
// - Shifting begins only while start is set and the count is nonzero.
// - Words move to a buffer, count minus one, shifted two bits per cycle.
// - Full flag at width-dependent maximum count; empty flag at zero count.
// - With module enable low the FIFO empties and count stays zero.
// - Input bits enter MSb first, or LSb first when direction bit is set.
// - Direction changes only input order; the remainder stays non-reflected.
// - Interrupt select 0 raises interrupt when count goes from 1 to 0.
// - Interrupt select 1 interrupts on hardware start clear, never on software clear.
// - Calculation finishes one idle cycle plus (length field plus one)/2 cycles, at least one, after the last word shifts.
// - Start bit clears itself when the calculation completes.
`ifndef CRC_CONSTS_SVH
`define CRC_CONSTS_SVH
// Register byte offsets
`define A_CTL1 8'h00
`define A_CTL2 8'h04
`define A_XORL 8'h08
`define A_XORH 8'h0C
`define A_DATL 8'h10
`define A_DATH 8'h14
`define A_RESL 8'h18
`define A_RESH 8'h1C
// Control one fields
`define C1_EN 15
`define C1_ISEL 5
`define C1_GO 4
`define C1_LSB 3
// Control two fields
`define C2_W_HI 12
`define C2_W_LO 8
`define C2_P_HI 4
`define C2_P_LO 0
// Depth selection
`define W_NARROW_MAX 5'h0F
`define W_MID_MIN 5'h08
`define DEPTH_WIDE 5'h04
`define DEPTH_MID 5'h08
`define DEPTH_NARROW 5'h10
// Misc constants
`define ALL_ONES 32'hFFFF_FFFF
`define MAX_IDX 5'h1F
`define CONST_TERM 32'h0000_0001
`define ZERO16 16'h0000
`define ZERO32 32'h0000_0000
`define HTRANS_ACT 1
`endif

/* File: design/crc_pkg.sv */
package crc_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SHIFT = 2'b01,
    S_DRAIN = 2'b10
  } eng_state_e;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } aphase_s;
endpackage

/* File: design/crc_step.sv */
`timescale 1ns/1ps
`include "crc_consts.svh"
// One bit of the shift engine
module crc_step (
  input wire logic [31:0] crc,
  input wire logic [31:0] terms,
  input wire logic [31:0] pmask,
  input wire logic [4:0] poly_length,
  input wire logic din,
  output logic [31:0] nxt
);
  // Feedback is input bit against top bit of the programmed length
  wire fb = din ^ crc[poly_length];
  // Constant term forced, top term implied by shifting out
  wire [31:0] taps = terms | `CONST_TERM;
  assign nxt = ((crc << 1) ^ (fb ? taps : `ZERO32)) & pmask;
endmodule

/* File: design/programmable_crc_generator.sv */
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "crc_consts.svh"
module programmable_crc_generator (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic crc_irq
);
  crc_pkg::aphase_s aph_ff;
  crc_pkg::aphase_s nxt_aph;
  crc_pkg::eng_state_e state_ff;
  crc_pkg::eng_state_e nxt_state;
  crc_pkg::word_t fifo_mem [16];
  crc_pkg::word_t buf_ff;
  crc_pkg::word_t nxt_buf;
  crc_pkg::word_t terms_ff;
  crc_pkg::word_t crc_ff;
  crc_pkg::word_t nxt_crc;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic en_ff;
  logic isel_ff;
  logic go_ff;
  logic lsb_ff;
  logic ran_ff;
  logic irq_ff;
  logic nxt_go;
  logic nxt_ran;
  logic nxt_irq;
  logic [4:0] width_ff;
  logic [4:0] poly_length_ff;
  logic [15:0] stage_ff;
  logic [3:0] wp_ff;
  logic [3:0] rp_ff;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic [5:0] pos_ff;
  logic [5:0] nxt_pos;
  logic [4:0] drain_ff;
  logic [4:0] nxt_drain;

  // Address phase capture; hsize is ignored, only the low half-word of hwdata is used
  wire take = hsel & htrans[`HTRANS_ACT] & hready;
  assign nxt_aph = '{valid: take, write: hwrite, addr: haddr[7:0]};

  // Data phase write strobes
  wire wr = aph_ff.valid & aph_ff.write;
  wire wr_c1 = wr & (aph_ff.addr == `A_CTL1);
  wire wr_c2 = wr & (aph_ff.addr == `A_CTL2);
  wire wr_xl = wr & (aph_ff.addr == `A_XORL);
  wire wr_xh = wr & (aph_ff.addr == `A_XORH);
  wire wr_dl = wr & (aph_ff.addr == `A_DATL);
  wire wr_dh = wr & (aph_ff.addr == `A_DATH);
  wire wr_rl = wr & (aph_ff.addr == `A_RESL);
  wire wr_rh = wr & (aph_ff.addr == `A_RESH);
  wire [15:0] wd = hwdata[15:0];

  // Width dependent depth and flags
  wire wide = width_ff > `W_NARROW_MAX;
  wire [4:0] depth_max = wide ? `DEPTH_WIDE :
    ((width_ff >= `W_MID_MIN) ? `DEPTH_MID : `DEPTH_NARROW);
  wire full = cnt_ff == depth_max;
  wire empty = cnt_ff == 5'h00;

  // Data width mask keeps only the configured bits
  wire [31:0] dmask = `ALL_ONES >> (`MAX_IDX - width_ff);
  wire [31:0] pmask = `ALL_ONES >> (`MAX_IDX - poly_length_ff);
  wire [31:0] raw_word = wide ? {wd, stage_ff} : {`ZERO16, wd};
  wire [31:0] in_word = raw_word & dmask;

  // Entry completes on the half that holds the top data bit
  wire entry = wide ? wr_dh : wr_dl;
  wire push = en_ff & entry & ~full;
  wire pop = en_ff & go_ff & (state_ff == crc_pkg::S_IDLE) & ~empty;

  // Bit selection for the two shifts of this cycle
  wire [5:0] nbits = {1'b0, width_ff} + 6'h01;
  wire [5:0] left = nbits - pos_ff;
  wire take2 = left > 6'h01;
  wire last = left <= 6'h02;
  wire [5:0] msb0 = {1'b0, width_ff} - pos_ff;
  wire [5:0] msb1 = msb0 - 6'h01;
  wire [5:0] lsb1 = pos_ff + 6'h01;
  wire [4:0] idx0 = lsb_ff ? pos_ff[4:0] : msb0[4:0];
  wire [4:0] idx1 = lsb_ff ? lsb1[4:0] : msb1[4:0];
  wire b0 = buf_ff[idx0];
  wire b1 = buf_ff[idx1];
  wire [31:0] step1, step2;

  // Two engine steps per cycle; result is never reflected
  crc_step u_step0 (
    .crc(crc_ff),
    .terms(terms_ff),
    .pmask(pmask),
    .poly_length(poly_length_ff),
    .din(b0),
    .nxt(step1)
  );
  crc_step u_step1 (
    .crc(step1),
    .terms(terms_ff),
    .pmask(pmask),
    .poly_length(poly_length_ff),
    .din(b1),
    .nxt(step2)
  );
  wire [31:0] shifted = take2 ? step2 : step1;

  // Tail delay after the last word and hardware finish
  wire [5:0] tail6 = ({1'b0, poly_length_ff} + 6'h01) >> 1;
  wire [4:0] tail = (tail6 == 6'h00) ? 5'h01 : tail6[4:0];
  wire in_drain = state_ff == crc_pkg::S_DRAIN;
  wire hw_fin = en_ff & in_drain & (drain_ff <= 5'h01);
  wire cnt_fall = en_ff & (cnt_ff == 5'h01) & (nxt_cnt == 5'h00);

  // Engine sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_pos = pos_ff;
    nxt_buf = buf_ff;
    nxt_drain = drain_ff;
    nxt_ran = ran_ff;
    case (state_ff)
      crc_pkg::S_IDLE: begin
        if (pop) begin
          nxt_buf = fifo_mem[rp_ff];
          nxt_pos = 6'h00;
          nxt_ran = 1'b1;
          nxt_state = crc_pkg::S_SHIFT;
        end else if (go_ff & ran_ff & empty) begin
          nxt_drain = tail;
          nxt_state = crc_pkg::S_DRAIN;
        end
      end
      crc_pkg::S_SHIFT: begin
        nxt_pos = pos_ff + 6'h02;
        if (last) begin
          nxt_state = crc_pkg::S_IDLE;
        end
      end
      crc_pkg::S_DRAIN: begin
        nxt_drain = drain_ff - 5'h01;
        if (hw_fin) begin
          nxt_ran = 1'b0;
          nxt_state = crc_pkg::S_IDLE;
        end
      end
      default: begin
        nxt_state = crc_pkg::S_IDLE;
      end
    endcase
    if (~en_ff) begin
      nxt_state = crc_pkg::S_IDLE;
      nxt_ran = 1'b0;
    end
  end

  // Count bookkeeping
  always_comb begin
    nxt_cnt = cnt_ff;
    if (push & ~pop) begin
      nxt_cnt = cnt_ff + 5'h01;
    end else if (pop & ~push) begin
      nxt_cnt = cnt_ff - 5'h01;
    end
    if (~en_ff) begin
      nxt_cnt = 5'h00;
    end
  end

  // Start bit: software set wins over hardware clear
  always_comb begin
    nxt_go = go_ff;
    if (hw_fin) begin
      nxt_go = 1'b0;
    end
    if (wr_c1) begin
      nxt_go = hwdata[`C1_GO];
    end
    if (~en_ff) begin
      nxt_go = 1'b0;
    end
  end

  // Result register: software writes win over the engine
  always_comb begin
    nxt_crc = crc_ff;
    if (state_ff == crc_pkg::S_SHIFT) begin
      nxt_crc = shifted;
    end
    if (wr_rl) begin
      nxt_crc[15:0] = wd;
    end
    if (wr_rh) begin
      nxt_crc[31:16] = wd;
    end
    if (~en_ff) begin
      nxt_crc = `ZERO32;
    end
  end

  // Interrupt source selection
  assign nxt_irq = isel_ff ? hw_fin : cnt_fall;

  // Read view, prepared in the address phase
  wire [15:0] c1_view = {en_ff, 2'b00, cnt_ff, full, empty, isel_ff, go_ff,
    lsb_ff, 3'b000};
  wire [15:0] c2_view = {3'b000, width_ff, 3'b000, poly_length_ff};
  wire [7:0] ra = haddr[7:0];
  always_comb begin
    case (ra)
      `A_CTL1: nxt_rdata = {`ZERO16, c1_view};
      `A_CTL2: nxt_rdata = {`ZERO16, c2_view};
      `A_XORL: nxt_rdata = {`ZERO16, terms_ff[15:0]};
      `A_XORH: nxt_rdata = {`ZERO16, terms_ff[31:16]};
      `A_RESL: nxt_rdata = {`ZERO16, crc_ff[15:0]};
      `A_RESH: nxt_rdata = {`ZERO16, crc_ff[31:16]};
      default: nxt_rdata = `ZERO32;
    endcase
  end

  // Bus side flops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aph_ff <= '0;
      rdata_ff <= `ZERO32;
    end else begin
      aph_ff <= nxt_aph;
      rdata_ff <= take ? nxt_rdata : rdata_ff;
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_ff <= 1'b0;
      isel_ff <= 1'b0;
      lsb_ff <= 1'b0;
      width_ff <= 5'h00;
      poly_length_ff <= 5'h00;
    end else if (wr_c1) begin
      en_ff <= hwdata[`C1_EN];
      isel_ff <= hwdata[`C1_ISEL];
      lsb_ff <= hwdata[`C1_LSB];
    end else if (wr_c2) begin
      width_ff <= hwdata[`C2_W_HI:`C2_W_LO];
      poly_length_ff <= hwdata[`C2_P_HI:`C2_P_LO];
    end
  end

  // Polynomial terms
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      terms_ff <= `ZERO32;
    end else if (wr_xl) begin
      terms_ff[15:0] <= wd;
    end else if (wr_xh) begin
      terms_ff[31:16] <= wd;
    end
  end

  // Low half staging for wide words
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage_ff <= `ZERO16;
    end else if (wr_dl) begin
      stage_ff <= wd;
    end
  end

  // FIFO storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      fifo_mem[wp_ff] <= in_word;
    end
  end

  // FIFO pointers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wp_ff <= 4'h0;
      rp_ff <= 4'h0;
    end else if (~en_ff) begin
      wp_ff <= 4'h0;
      rp_ff <= 4'h0;
    end else begin
      wp_ff <= push ? wp_ff + 4'h1 : wp_ff;
      rp_ff <= pop ? rp_ff + 4'h1 : rp_ff;
    end
  end

  // Engine and status flops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= crc_pkg::S_IDLE;
      cnt_ff <= 5'h00;
      pos_ff <= 6'h00;
      buf_ff <= `ZERO32;
      drain_ff <= 5'h00;
      ran_ff <= 1'b0;
      go_ff <= 1'b0;
      crc_ff <= `ZERO32;
      irq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      pos_ff <= nxt_pos;
      buf_ff <= nxt_buf;
      drain_ff <= nxt_drain;
      ran_ff <= nxt_ran;
      go_ff <= nxt_go;
      crc_ff <= nxt_crc;
      irq_ff <= nxt_irq;
    end
  end

  assign hrdata = rdata_ff;
  assign crc_irq = irq_ff;
  // Slave always ready with OKAY
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  en_off_a: assert property (!en_ff |=> cnt_ff == 5'h00 && state_ff == crc_pkg::S_IDLE)
    else $error("count not cleared while disabled");
  no_start_a: assert property (state_ff == crc_pkg::S_IDLE && !go_ff
    |=> state_ff != crc_pkg::S_SHIFT)
    else $error("shift began without start");
  push_inc_a: assert property (push && !pop && en_ff |=> cnt_ff == $past(cnt_ff) + 5'h01)
    else $error("entry did not raise count");
  pop_dec_a: assert property (pop && !push |=> cnt_ff == $past(cnt_ff) - 5'h01)
    else $error("buffer load did not lower count");
  full_hold_a: assert property (en_ff && full && entry && !pop |=> cnt_ff == $past(cnt_ff))
    else $error("write into full fifo counted");
  depth_cap_a: assert property (cnt_ff <= depth_max || $past(wr_c2))
    else $error("count above depth");
  shift_two_a: assert property (state_ff == crc_pkg::S_SHIFT && !last && en_ff
    |=> state_ff == crc_pkg::S_SHIFT && pos_ff == $past(pos_ff) + 6'h02)
    else $error("shift rate wrong");
  irq_fall_a: assert property (en_ff && !isel_ff && cnt_ff == 5'h01 && pop && !push
    |=> crc_irq)
    else $error("no interrupt on count fall");
  finish_a: assert property (hw_fin && !wr_c1 |=> !go_ff && crc_irq == $past(isel_ff))
    else $error("finish did not clear start");
  sw_clear_a: assert property (wr_c1 && !hwdata[`C1_GO] && !hw_fin && isel_ff
    |=> !crc_irq)
    else $error("software clear raised interrupt");
  fin_c: cover property (hw_fin && isel_ff);
  full_c: cover property (full && en_ff);
  lsb_c: cover property (state_ff == crc_pkg::S_SHIFT && lsb_ff);
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`include "crc_consts.svh"
module testbench;
  logic sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp, crc_irq;
  logic [31:0] haddr, hwdata, hrdata, rd, exp, dw;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] db;
  logic [4:0] wtab [5] = '{5'h05, 5'h08, 5'h0F, 5'h10, 5'h1F};
  logic [4:0] dtab [5] = '{5'h10, 5'h08, 5'h08, 5'h04, 5'h04};
  int fail_count, checks, cycles, irq_count, irq0;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  programmable_crc_generator i_programmable_crc_generator (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .crc_irq(crc_irq)
  );

  // Clock generation
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Interrupt pulse counter and hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (crc_irq === 1'b1) irq_count <= irq_count + 1;
    if (cycles == 30000) begin
      fail_count++;
      results();
    end
  end

  // Compare and report
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  // Verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One AHB-Lite single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("okay response", 32'h0000_0000, {31'h0000_0000, hresp});
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(n, {16'h0000, e}, rd);
  endtask

  // One FIFO entry; wide entries go low half first
  task automatic put(input logic [4:0] w, input logic [31:0] d);
    wr(`A_DATL, d[15:0]);
    if (w > 5'h0F) wr(`A_DATH, d[31:16]);
  endtask

  // Poll until the start bit drops, bounded
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      bus(1'b0, `A_CTL1, 16'h0000);
      n++;
    end while (rd[`C1_GO] !== 1'b0 && n < 200);
  endtask

  // Bit-serial reference remainder
  function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [31:0] t,
      input int pl, input logic [31:0] d, input int w, input logic lsb);
    logic [31:0] m;
    logic b, fb;
    m = (pl == 31) ? 32'hFFFF_FFFF : ((32'h0000_0001 << (pl + 1)) - 32'h0000_0001);
    for (int i = 0; i < w; i++) begin
      b = lsb ? d[i] : d[w - 1 - i];
      fb = b ^ c[pl];
      c = ((c << 1) ^ (fb ? (t | 32'h0000_0001) : 32'h0000_0000)) & m;
    end
    return c;
  endfunction

  // Main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    fail_count = 0;
    checks = 0;
    cycles = 0;
    irq_count = 0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk("control one after reset", `A_CTL1, 16'h0040);
    wr(8'h24, 16'hFFFF);
    rdchk("unmapped read", 8'h20, 16'h0000);
    // Fill past depth for each width class, then disable
    foreach (wtab[k]) begin
      wr(`A_CTL1, 16'h8000);
      wr(`A_CTL2, {3'b000, wtab[k], 8'h00});
      for (int e = 0; e <= dtab[k]; e++) put(wtab[k], 32'hFFFF_FFFF);
      rdchk("full count", `A_CTL1, {3'b100, dtab[k], 8'h80});
      wr(`A_CTL1, 16'h0000);
      rdchk("count after disable", `A_CTL1, 16'h0040);
    end
    // Eight bit polynomial, five bit data (odd, single last step), MSb first, finish interrupt
    wr(`A_CTL1, 16'h8000);
    wr(`A_CTL2, 16'h0407);
    wr(`A_XORL, 16'h0006);
    wr(`A_XORH, 16'h0000);
    exp = 32'h0000_0000;
    for (int e = 0; e < 16; e++) begin
      db = 8'hA5 + 8'h13 * e[7:0];
      put(5'h04, {24'h00_0000, db});
      exp = crc_ref(exp, 32'h0000_0007, 7, {27'h000_0000, db[4:0]}, 5, 1'b0);
    end
    wr(`A_RESL, 16'h0000);
    wr(`A_RESH, 16'h0000);
    rdchk("result before start", `A_RESL, 16'h0000);
    irq0 = irq_count;
    wr(`A_CTL1, 16'h8030);
    wait_done();
    rdchk("short remainder", `A_RESL, exp[15:0]);
    rdchk("short remainder high", `A_RESH, 16'h0000);
    chk("finish interrupt", irq0 + 1, irq_count);
    // Start with no data, then clear start by software
    wr(`A_CTL1, 16'h8030);
    wr(`A_CTL1, 16'h8020);
    repeat (8) @(posedge sys_clk);
    chk("software clear interrupt", irq0 + 1, irq_count);
    // Full order polynomial, 32 bit data, LSb first, drain interrupt
    wr(`A_CTL1, 16'h0000);
    wr(`A_CTL1, 16'h8008);
    wr(`A_CTL2, 16'h1F1F);
    wr(`A_XORL, 16'h1DB7);
    wr(`A_XORH, 16'h04C1);
    wr(`A_RESL, 16'h0000);
    wr(`A_RESH, 16'h0000);
    wr(`A_DATL, 16'h1234);
    rdchk("count after low half", `A_CTL1, 16'h8048);
    wr(`A_DATH, 16'hABCD);
    exp = crc_ref(32'h0000_0000, 32'h04C1_1DB7, 31, 32'hABCD_1234, 32, 1'b1);
    for (int e = 1; e < 4; e++) begin
      dw = 32'h1357_9BDF ^ (32'h0101_0101 * e);
      put(5'h1F, dw);
      exp = crc_ref(exp, 32'h04C1_1DB7, 31, dw, 32, 1'b1);
    end
    irq0 = irq_count;
    wr(`A_CTL1, 16'h8018);
    // One more word fed while the engine runs, as space has freed up
    put(5'h1F, 32'h2468_ACE0);
    exp = crc_ref(exp, 32'h04C1_1DB7, 31, 32'h2468_ACE0, 32, 1'b1);
    wait_done();
    rdchk("wide remainder low", `A_RESL, exp[15:0]);
    rdchk("wide remainder high", `A_RESH, exp[31:16]);
    chk("drain interrupt", irq0 + 1, irq_count);
    rdchk("empty after run", `A_CTL1, 16'h8048);
    results();
  end
endmodule
